// ### src/gyro_regs_pkg.sv
`default_nettype none

package gyro_regs_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_MAKER_CODE   = 7'h00;  // Maker identification byte.
  localparam logic [6:0] ADDR_ELEMENT_CODE = 7'h01;  // Sensor element identification byte.
  localparam logic [6:0] ADDR_PART_CODE    = 7'h02;  // Part identification byte.
  localparam logic [6:0] ADDR_REVISION     = 7'h03;  // Silicon revision byte.
  localparam logic [6:0] ADDR_SERIAL_0     = 7'h04;  // Serial number, least significant byte.
  localparam logic [6:0] ADDR_SERIAL_1     = 7'h05;  // Serial number, second byte.
  localparam logic [6:0] ADDR_SERIAL_2     = 7'h06;  // Serial number, third byte.
  localparam logic [6:0] ADDR_SERIAL_3     = 7'h07;  // Serial number, most significant byte.
  localparam logic [6:0] ADDR_RATE_X_LOW   = 7'h08;  // X rate low byte.
  localparam logic [6:0] ADDR_RATE_X_HIGH  = 7'h09;  // X rate high byte.
  localparam logic [6:0] ADDR_RATE_Y_LOW   = 7'h0A;  // Y rate low byte.
  localparam logic [6:0] ADDR_RATE_Y_HIGH  = 7'h0B;  // Y rate high byte.
  localparam logic [6:0] ADDR_TEMP_LOW     = 7'h0C;  // Temperature bits 7:0.
  localparam logic [6:0] ADDR_TEMP_HIGH    = 7'h0D;  // Temperature bits 11:8.
  localparam logic [6:0] ADDR_RESERVED_A   = 7'h0E;  // First reserved byte.
  localparam logic [6:0] ADDR_RESERVED_B   = 7'h0F;  // Second reserved byte.
  localparam logic [6:0] ADDR_POWER_CTRL   = 7'h10;  // Power control.
  localparam logic [6:0] ADDR_FILTER_SEL   = 7'h11;  // Filter corner select.
  localparam logic [6:0] ADDR_READY_CFG    = 7'h12;  // Ready pin configuration.

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int         POS_TEMP_ENABLE   = 0;      // Power control: temperature sensor enable.
  localparam int         POS_MEASURE       = 1;      // Power control: measurement mode.
  localparam logic [7:0] RESET_ZERO        = 8'h00;  // Default of control, data and first reserved byte.
  localparam logic [7:0] RESET_RESERVED_B  = 8'h03;  // Default of second reserved byte.
  localparam logic [1:0] SYNC_DATA_READY   = 2'h1;   // Sync field code for data-ready output.
  localparam logic [7:0] MASK_POWER_CTRL   = 8'h03;  // Writable bits of power control.
  localparam logic [7:0] MASK_FILTER_SEL   = 8'hF7;  // Writable bits of filter select.
  localparam logic [7:0] MASK_READY_CFG    = 8'h03;  // Writable bits of ready configuration.

  // ------------------------------------------------------------
  // Serial framing
  // ------------------------------------------------------------
  localparam logic [2:0] LAST_BIT          = 3'h7;   // Index of the last bit of a byte.
  localparam logic       DIR_READ          = 1'b1;   // Direction bit value for a read.

endpackage : gyro_regs_pkg

`default_nettype wire

// ### src/gyro_register_map.sv
// Functional notes
// - Fixed read-only identification bytes at 0x00-0x02.
// - Read-only revision byte at 0x03.
// - Serial number bytes 0x04-0x07, LSB first.
// - Rates two's complement, low byte even address.
// - Rate bytes coherent within one burst.
// - Temperature 12 bits, upper nibble reads zero.
// - Temperature ten counts per degree, zero-based.
// - Temperature plus rates coherent within burst.
// - Power bit 0 enables temperature sensor.
// - Power bit 1 selects standby or measurement.
// - Registers take listed defaults at reset.
// - Starts in standby until measurement set.
// - High-pass select bits 7:4, bit 3 zero.
// - Low-pass select in filter bits 2:0.
// - Sync 01 drives ready high until read.
// - Command is direction, address, then data.
// - Standby allows single-register transfers only.
// - Leaving measurement clears preserved offset estimate.
`timescale 1ns/1ps
`default_nettype none

module gyro_register_map #(
  parameter logic [7:0] MAKER_ID    = 8'h5A,  // Arbitrary value.
  parameter logic [7:0] ELEMENT_ID  = 8'h3C,  // Arbitrary value.
  parameter logic [7:0] PART_ID     = 8'h66,  // Arbitrary value.
  parameter logic [7:0] REVISION_ID = 8'h01   // Arbitrary value.
) (
  input  wire logic        clock,                   // System clock, 200 MHz.
  input  wire logic        sys_rst,                 // Synchronous reset, active high.
  input  wire logic        spi_cs_n,                // Serial select, active low.
  input  wire logic        spi_sclk,                // Serial clock, idles high.
  input  wire logic        spi_sdi,                 // Serial data from host.
  output logic             spi_sdo,                 // Serial data to host.
  input  wire logic [31:0] serial_number,           // Per-part serial number.
  input  wire logic        sample_valid,            // One-cycle pulse: new sample on inputs.
  input  wire logic [15:0] rate_x_in,               // X rate sample.
  input  wire logic [15:0] rate_y_in,               // Y rate sample.
  input  wire logic [11:0] temp_in,                 // Temperature sample.
  output logic             measure_enable,          // Measurement mode active.
  output logic             temp_sensor_enable,      // Temperature sensor powered.
  output logic [3:0]       highpass_corner_select,  // High-pass pole code.
  output logic [2:0]       lowpass_corner_select,   // Low-pass pole code.
  output logic             offset_clear,            // Pulse: drop the held offset estimate.
  output logic             ready_analog_select_pin  // Data-ready pin level.
);

  // ------------------------------------------------------------
  // Serial port state
  // ------------------------------------------------------------
  logic       sclk_q_r, sclk_q_nxt;        // Last sampled serial clock.
  logic [2:0] bit_cnt_r, bit_cnt_nxt;      // Bit index within current byte.
  logic [6:0] shift_r, shift_nxt;          // Incoming bits of current byte.
  logic [7:0] tx_r, tx_nxt;                // Outgoing byte, MSB first.
  logic       sdo_r, sdo_nxt;              // Registered serial output.
  logic       in_cmd_r, in_cmd_nxt;        // High while the command byte arrives.
  logic       dir_r, dir_nxt;              // Direction of the current frame.
  logic [6:0] addr_r, addr_nxt;            // Current register address.
  logic       first_done_r, first_done_nxt; // One data byte already moved.
  logic [7:0] power_r, power_nxt;          // Power control register.
  logic [7:0] filter_r, filter_nxt;        // Filter select register.
  logic [7:0] ready_cfg_r, ready_cfg_nxt;  // Ready pin configuration register.
  logic       data_read;                   // A data register is read this cycle.

  // ------------------------------------------------------------
  // Sample path state
  // ------------------------------------------------------------
  logic [15:0] rate_x_r, rate_x_nxt;       // Visible X rate.
  logic [15:0] rate_y_r, rate_y_nxt;       // Visible Y rate.
  logic [11:0] temp_r, temp_nxt;           // Visible temperature.
  logic [15:0] pend_x_r, pend_x_nxt;       // Waiting X rate.
  logic [15:0] pend_y_r, pend_y_nxt;       // Waiting Y rate.
  logic [11:0] pend_t_r, pend_t_nxt;       // Waiting temperature.
  logic        pend_r, pend_nxt;           // A waiting sample exists.
  logic        drdy_r, drdy_nxt;           // Data-ready flag.
  logic        clr_r, clr_nxt;             // Offset clear pulse.

  // Read decode; unmapped addresses read as zero.
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      gyro_regs_pkg::ADDR_MAKER_CODE:   v = MAKER_ID;
      gyro_regs_pkg::ADDR_ELEMENT_CODE: v = ELEMENT_ID;
      gyro_regs_pkg::ADDR_PART_CODE:    v = PART_ID;
      gyro_regs_pkg::ADDR_REVISION:     v = REVISION_ID;
      gyro_regs_pkg::ADDR_SERIAL_0:     v = serial_number[7:0];
      gyro_regs_pkg::ADDR_SERIAL_1:     v = serial_number[15:8];
      gyro_regs_pkg::ADDR_SERIAL_2:     v = serial_number[23:16];
      gyro_regs_pkg::ADDR_SERIAL_3:     v = serial_number[31:24];
      gyro_regs_pkg::ADDR_RATE_X_LOW:   v = rate_x_r[7:0];
      gyro_regs_pkg::ADDR_RATE_X_HIGH:  v = rate_x_r[15:8];
      gyro_regs_pkg::ADDR_RATE_Y_LOW:   v = rate_y_r[7:0];
      gyro_regs_pkg::ADDR_RATE_Y_HIGH:  v = rate_y_r[15:8];
      gyro_regs_pkg::ADDR_TEMP_LOW:     v = temp_r[7:0];
      gyro_regs_pkg::ADDR_TEMP_HIGH:    v = {4'h0, temp_r[11:8]};
      gyro_regs_pkg::ADDR_RESERVED_A:   v = gyro_regs_pkg::RESET_ZERO;
      gyro_regs_pkg::ADDR_RESERVED_B:   v = gyro_regs_pkg::RESET_RESERVED_B;
      gyro_regs_pkg::ADDR_POWER_CTRL:   v = power_r;
      gyro_regs_pkg::ADDR_FILTER_SEL:   v = filter_r;
      gyro_regs_pkg::ADDR_READY_CFG:    v = ready_cfg_r;
      default:                          v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // True for the six rate and temperature bytes.
  function automatic logic is_data_addr(input logic [6:0] a);
    return (a >= gyro_regs_pkg::ADDR_RATE_X_LOW) && (a <= gyro_regs_pkg::ADDR_TEMP_HIGH);
  endfunction : is_data_addr

  // ------------------------------------------------------------
  // Serial port next state
  // ------------------------------------------------------------
  // The serial pins are sampled on the system clock, so a serial clock of
  // up to 5 MHz leaves many system cycles per half period for the decode.
  always_comb begin
    logic [7:0] rx;
    logic [6:0] next_addr;
    rx             = {shift_r, spi_sdi};
    next_addr      = addr_r + 7'h01;
    sclk_q_nxt     = spi_sclk;
    bit_cnt_nxt    = bit_cnt_r;
    shift_nxt      = shift_r;
    tx_nxt         = tx_r;
    sdo_nxt        = sdo_r;
    in_cmd_nxt     = in_cmd_r;
    dir_nxt        = dir_r;
    addr_nxt       = addr_r;
    first_done_nxt = first_done_r;
    power_nxt      = power_r;
    filter_nxt     = filter_r;
    ready_cfg_nxt  = ready_cfg_r;
    data_read      = 1'b0;
    if (spi_cs_n) begin
      // Frame ended: rearm for a fresh command byte.
      bit_cnt_nxt    = 3'h0;
      in_cmd_nxt     = 1'b1;
      first_done_nxt = 1'b0;
      tx_nxt         = 8'h00;
      sdo_nxt        = 1'b0;
    end else if (spi_sclk && !sclk_q_r) begin
      // Rising serial edge: take one input bit.
      shift_nxt   = rx[6:0];
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == gyro_regs_pkg::LAST_BIT) begin
        if (in_cmd_r) begin
          in_cmd_nxt = 1'b0;
          dir_nxt    = rx[7];
          addr_nxt   = rx[6:0];
          tx_nxt     = (rx[7] == gyro_regs_pkg::DIR_READ) ? reg_read(rx[6:0]) : 8'h00;
          data_read  = (rx[7] == gyro_regs_pkg::DIR_READ) && is_data_addr(rx[6:0]);
        end else if (!(first_done_r && !power_r[gyro_regs_pkg::POS_MEASURE])) begin
          first_done_nxt = 1'b1;
          if (dir_r != gyro_regs_pkg::DIR_READ) begin
            case (addr_r)
              gyro_regs_pkg::ADDR_POWER_CTRL: power_nxt     = rx & gyro_regs_pkg::MASK_POWER_CTRL;
              gyro_regs_pkg::ADDR_FILTER_SEL: filter_nxt    = rx & gyro_regs_pkg::MASK_FILTER_SEL;
              gyro_regs_pkg::ADDR_READY_CFG:  ready_cfg_nxt = rx & gyro_regs_pkg::MASK_READY_CFG;
              default:                        ;
            endcase
          end
          addr_nxt = next_addr;
          if ((dir_r == gyro_regs_pkg::DIR_READ) && power_r[gyro_regs_pkg::POS_MEASURE]) begin
            tx_nxt    = reg_read(next_addr);
            data_read = is_data_addr(next_addr);
          end else begin
            tx_nxt = 8'h00;
          end
        end else begin
          // Extra bytes in standby move nothing.
          tx_nxt = 8'h00;
        end
      end
    end else if (!spi_sclk && sclk_q_r) begin
      // Falling serial edge: present the next output bit.
      sdo_nxt = tx_r[7];
      tx_nxt  = {tx_r[6:0], 1'b0};
    end
  end

  // Serial port registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclk_q_r     <= 1'b1;
      bit_cnt_r    <= 3'h0;
      shift_r      <= 7'h00;
      tx_r         <= 8'h00;
      sdo_r        <= 1'b0;
      in_cmd_r     <= 1'b1;
      dir_r        <= 1'b0;
      addr_r       <= 7'h00;
      first_done_r <= 1'b0;
      power_r      <= gyro_regs_pkg::RESET_ZERO;
      filter_r     <= gyro_regs_pkg::RESET_ZERO;
      ready_cfg_r  <= gyro_regs_pkg::RESET_ZERO;
    end else begin
      sclk_q_r     <= sclk_q_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
      shift_r      <= shift_nxt;
      tx_r         <= tx_nxt;
      sdo_r        <= sdo_nxt;
      in_cmd_r     <= in_cmd_nxt;
      dir_r        <= dir_nxt;
      addr_r       <= addr_nxt;
      first_done_r <= first_done_nxt;
      power_r      <= power_nxt;
      filter_r     <= filter_nxt;
      ready_cfg_r  <= ready_cfg_nxt;
    end
  end

  // ------------------------------------------------------------
  // Sample path next state
  // ------------------------------------------------------------
  // New samples wait while a frame is open and become visible only between
  // frames, so one burst never sees half of an old and half of a new value.
  always_comb begin
    rate_x_nxt = rate_x_r;
    rate_y_nxt = rate_y_r;
    temp_nxt   = temp_r;
    pend_x_nxt = pend_x_r;
    pend_y_nxt = pend_y_r;
    pend_t_nxt = pend_t_r;
    pend_nxt   = pend_r;
    drdy_nxt   = drdy_r;
    clr_nxt    = power_r[gyro_regs_pkg::POS_MEASURE] && !power_nxt[gyro_regs_pkg::POS_MEASURE];
    if (data_read) begin
      drdy_nxt = 1'b0;
    end
    if (sample_valid && power_r[gyro_regs_pkg::POS_MEASURE]) begin
      pend_x_nxt = rate_x_in;
      pend_y_nxt = rate_y_in;
      pend_nxt   = 1'b1;
      if (power_r[gyro_regs_pkg::POS_TEMP_ENABLE]) begin
        pend_t_nxt = temp_in;
      end
    end
    if (spi_cs_n && pend_r) begin
      rate_x_nxt = pend_x_r;
      rate_y_nxt = pend_y_r;
      temp_nxt   = pend_t_r;
      pend_nxt   = sample_valid && power_r[gyro_regs_pkg::POS_MEASURE];
      drdy_nxt   = 1'b1;
    end
  end

  // Sample path registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rate_x_r <= 16'h0000;
      rate_y_r <= 16'h0000;
      temp_r   <= 12'h000;
      pend_x_r <= 16'h0000;
      pend_y_r <= 16'h0000;
      pend_t_r <= 12'h000;
      pend_r   <= 1'b0;
      drdy_r   <= 1'b0;
      clr_r    <= 1'b0;
    end else begin
      rate_x_r <= rate_x_nxt;
      rate_y_r <= rate_y_nxt;
      temp_r   <= temp_nxt;
      pend_x_r <= pend_x_nxt;
      pend_y_r <= pend_y_nxt;
      pend_t_r <= pend_t_nxt;
      pend_r   <= pend_nxt;
      drdy_r   <= drdy_nxt;
      clr_r    <= clr_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign spi_sdo                 = sdo_r;
  assign measure_enable          = power_r[gyro_regs_pkg::POS_MEASURE];
  assign temp_sensor_enable      = power_r[gyro_regs_pkg::POS_TEMP_ENABLE];
  assign highpass_corner_select  = filter_r[7:4];
  assign lowpass_corner_select   = filter_r[2:0];
  assign offset_clear            = clr_r;
  // pin follows flag in sync mode
  assign ready_analog_select_pin = (ready_cfg_r[1:0] == gyro_regs_pkg::SYNC_DATA_READY) && drdy_r;

endmodule : gyro_register_map

`default_nettype wire

// ### bench/gyro_register_map_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------
// Port checker for the register map
// ------------------------------------------
module gyro_register_map_assertions (
  input wire logic       clock,                   // System clock.
  input wire logic       sys_rst,                 // Synchronous reset.
  input wire logic       spi_cs_n,                // Serial select, active low.
  input wire logic       spi_sclk,                // Serial clock.
  input wire logic       spi_sdo,                 // Serial data out.
  input wire logic       measure_enable,          // Measurement mode.
  input wire logic       temp_sensor_enable,      // Temperature sensor on.
  input wire logic [3:0] highpass_corner_select,  // High-pass code.
  input wire logic [2:0] lowpass_corner_select,   // Low-pass code.
  input wire logic       offset_clear,            // Offset drop pulse.
  input wire logic       ready_analog_select_pin  // Data-ready pin.
);
  logic rst_seen_r;  // High on the first cycle after reset.

  // Remember reset, so defaults are judged right at release.
  always_ff @(posedge clock) begin
    rst_seen_r <= sys_rst;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_reset_defaults;
    rst_seen_r |-> !measure_enable && !temp_sensor_enable && highpass_corner_select == 4'h0
      && lowpass_corner_select == 3'h0 && !offset_clear && !ready_analog_select_pin && !spi_sdo;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("outputs not at default after reset");
  property p_measure_in_frame;
    $changed(measure_enable) |-> !$past(spi_cs_n);
  endproperty
  a_measure_in_frame: assert property (p_measure_in_frame) else $error("measure changed outside a frame");
  property p_temp_in_frame;
    $changed(temp_sensor_enable) |-> !$past(spi_cs_n);
  endproperty
  a_temp_in_frame: assert property (p_temp_in_frame) else $error("temp enable changed outside a frame");
  property p_filter_in_frame;
    $changed({highpass_corner_select, lowpass_corner_select}) |-> !$past(spi_cs_n);
  endproperty
  a_filter_in_frame: assert property (p_filter_in_frame) else $error("filter changed outside a frame");
  property p_offset_on_leave;
    $fell(measure_enable) |-> ##[0:1] offset_clear;
  endproperty
  a_offset_on_leave: assert property (p_offset_on_leave) else $error("no offset clear on leaving measure");
  property p_offset_cause;
    offset_clear |-> !measure_enable && ($past(measure_enable) || $past(measure_enable, 2));
  endproperty
  a_offset_cause: assert property (p_offset_cause) else $error("offset clear without measure exit");
  property p_offset_pulse;
    offset_clear |=> !offset_clear;
  endproperty
  a_offset_pulse: assert property (p_offset_pulse) else $error("offset clear longer than one cycle");
  property p_sdo_idle;
    spi_cs_n [*3] |-> !spi_sdo;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("serial out not low while deselected");
  property p_sdo_after_fall;
    !spi_cs_n && $changed(spi_sdo) |-> !$past(spi_sclk) || !$past(spi_sclk, 2);
  endproperty
  a_sdo_after_fall: assert property (p_sdo_after_fall) else $error("serial out moved without clock fall");
endmodule : gyro_register_map_assertions

`default_nettype wire

// ### bench/gyro_spi_host.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------
// Serial host model, clock idles high
// ------------------------------------------
module gyro_spi_host (
  input  wire logic clock,     // System clock, drives timing.
  input  wire logic spi_sdo,   // Data from the device.
  output var  logic spi_cs_n,  // Select, active low.
  output var  logic spi_sclk,  // Serial clock.
  output var  logic spi_sdi    // Data to the device.
);
  logic [7:0] rd [0:7];  // Bytes captured in the last frame.

  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b1;
    spi_sdi  = 1'b0;
  end

  // Each clock level lasts three system cycles, well above the one needed.
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clock);
      spi_sclk = 1'b0;
      spi_sdi  = tx[i];
      repeat (3) @(negedge clock);
      spi_sclk = 1'b1;
      rx[i]    = spi_sdo;
      repeat (2) @(negedge clock);
    end
  endtask : byte_io

  // One frame: command byte, then n data bytes of value wd.
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [7:0] wd);
    logic [7:0] dummy;
    @(negedge clock);
    spi_cs_n = 1'b0;
    repeat (2) @(negedge clock);
    byte_io(cmd, dummy);
    for (int k = 0; k < n; k++) begin
      byte_io(wd, rd[k]);
    end
    repeat (2) @(negedge clock);
    spi_cs_n = 1'b1;
    // A released line is not left at its last value.
    spi_sdi  = ~spi_sdi;
    repeat (4) @(negedge clock);
  endtask : xfer
endmodule : gyro_spi_host

`default_nettype wire

// ### bench/gyro_register_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module gyro_register_map_tb_top;
  logic        clock, sys_rst, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, sample_valid;
  logic [31:0] serial_number;
  logic [15:0] rate_x_in, rate_y_in;
  logic [11:0] temp_in;
  logic        measure_enable, temp_sensor_enable, offset_clear, ready_analog_select_pin;
  logic [3:0]  highpass_corner_select;
  logic [2:0]  lowpass_corner_select;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          clr_cnt   = 0;  // Offset drop pulses seen.
  localparam logic [7:0] ID [0:3] = '{8'hC3, 8'h4B, 8'h2E, 8'h07};  // Arbitrary identity values.

  gyro_register_map #(.MAKER_ID(ID[0]), .ELEMENT_ID(ID[1]), .PART_ID(ID[2]), .REVISION_ID(ID[3])) dut_u (
    .clock, .sys_rst, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .serial_number, .sample_valid, .rate_x_in,
    .rate_y_in, .temp_in, .measure_enable, .temp_sensor_enable, .highpass_corner_select,
    .lowpass_corner_select, .offset_clear, .ready_analog_select_pin);
  gyro_spi_host h_u (.clock, .spi_sdo, .spi_cs_n, .spi_sclk, .spi_sdi);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Count offset drop pulses away from the launching edge; only the exit from measurement may cause one.
  always @(negedge clock) begin
    if (offset_clear === 1'b1) clr_cnt++;
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    h_u.xfer({1'b0, a}, 1, d);
  endtask : wr

  task automatic rd(input logic [6:0] a, input int n);
    h_u.xfer({1'b1, a}, n, 8'h00);
  endtask : rd

  // One-cycle sample pulse, as the sensor path delivers it.
  task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [11:0] t);
    @(negedge clock);
    {rate_x_in, rate_y_in, temp_in, sample_valid} = {x, y, t, 1'b1};
    @(negedge clock);
    sample_valid = 1'b0;
  endtask : smp

  // Burst over rates and temperature, compared byte by byte.
  task automatic burst_chk(input logic [15:0] x, input logic [15:0] y, input logic [11:0] t);
    logic [7:0] ex [0:5];
    ex = '{x[7:0], x[15:8], y[7:0], y[15:8], t[7:0], {4'h0, t[11:8]}};
    rd(7'h08, 6);
    for (int k = 0; k < 6; k++) begin
      chk("rate_temp", h_u.rd[k], ex[k]);
    end
  endtask : burst_chk

  function automatic logic [7:0] dflt(input int a);
    if (a < 4) return ID[a];
    if (a < 8) return serial_number[8*(a-4) +: 8];
    return (a == 15) ? 8'h03 : 8'h00;
  endfunction : dflt

  initial begin
    {sys_rst, sample_valid, rate_x_in, rate_y_in, temp_in} = {1'b1, 1'b0, 44'h0};
    serial_number = 32'h8765_4321;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    chk("ctl", {measure_enable, temp_sensor_enable, highpass_corner_select, lowpass_corner_select}, 16'h0);
    // Second pass repeats after trying to overwrite every fixed byte.
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 19; a++) begin
        rd(a[6:0], 1);
        chk("reg", h_u.rd[0], dflt(a));
        if (p == 0 && a < 16) wr(a[6:0], 8'hFF);
      end
    end
    rd(7'h00, 2);
    chk("standby_burst", h_u.rd[1], 16'h0);
    wr(7'h11, 8'hFF);
    rd(7'h11, 1);
    chk("filter", h_u.rd[0], 16'hF7);
    chk("corners", {highpass_corner_select, lowpass_corner_select}, 16'h7F);
    wr(7'h12, 8'hFF);
    rd(7'h12, 1);
    chk("ready_cfg", h_u.rd[0], 16'h03);
    wr(7'h12, 8'h01);
    wr(7'h10, 8'h03);
    chk("power", {measure_enable, temp_sensor_enable}, 16'h3);
    smp(16'h8001, 16'h7FFE, 12'hF9C);
    repeat (3) @(negedge clock);
    chk("ready_set", ready_analog_select_pin, 16'h1);
    // Another sync code gates the pin off; a write frame keeps the flag.
    wr(7'h12, 8'h02);
    chk("ready_gate", ready_analog_select_pin, 16'h0);
    wr(7'h12, 8'h01);
    chk("ready_back", ready_analog_select_pin, 16'h1);
    burst_chk(16'h8001, 16'h7FFE, 12'hF9C);
    chk("ready_clr", ready_analog_select_pin, 16'h0);
    // A sample arriving mid burst must not split the values read.
    fork
      burst_chk(16'h8001, 16'h7FFE, 12'hF9C);
      begin
        repeat (60) @(negedge clock);
        smp(16'h1234, 16'hFEDC, 12'h0FA);
      end
    join
    chk("ready_new", ready_analog_select_pin, 16'h1);
    burst_chk(16'h1234, 16'hFEDC, 12'h0FA);
    wr(7'h10, 8'h02);
    smp(16'h0001, 16'h0002, 12'h123);
    burst_chk(16'h0001, 16'h0002, 12'h0FA);
    // A filter change while measuring must not drop the held offset.
    wr(7'h11, 8'h00);
    chk("corners_meas", {highpass_corner_select, lowpass_corner_select}, 16'h0);
    wr(7'h10, 8'h00);
    repeat (4) @(negedge clock);
    chk("standby", measure_enable, 16'h0);
    chk("offset_clear", clr_cnt[15:0], 16'h1);
    final_report();
  end

  // Hang guard: a run this long is a failure.
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    final_report();
  end
endmodule : gyro_register_map_tb_top

bind gyro_register_map gyro_register_map_assertions chk_u (
  .clock, .sys_rst, .spi_cs_n, .spi_sclk, .spi_sdo, .measure_enable, .temp_sensor_enable,
  .highpass_corner_select, .lowpass_corner_select, .offset_clear, .ready_analog_select_pin);

`default_nettype wire
